//--- design/tap_pkg.sv
// tap_pkg: constants and state encoding for the boundary-scan test port
// assumes: included by the tap port top and its edge sampler
package tap_pkg;

    // ------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h2,
        ST_CAP_DR     = 4'h3,
        ST_SHIFT_DR   = 4'h4,
        ST_EXIT1_DR   = 4'h5,
        ST_PAUSE_DR   = 4'h6,
        ST_EXIT2_DR   = 4'h7,
        ST_UPD_DR     = 4'h8,
        ST_SEL_IR     = 4'h9,
        ST_CAP_IR     = 4'hA,
        ST_SHIFT_IR   = 4'hB,
        ST_EXIT1_IR   = 4'hC,
        ST_PAUSE_IR   = 4'hD,
        ST_EXIT2_IR   = 4'hE,
        ST_UPD_IR     = 4'hF
    } tap_state_e;

    // ------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------
    localparam int          IR_WIDTH      = 4;
    localparam int          ID_WIDTH      = 32;
    localparam logic [3:0]  IR_RESET      = 4'h1;  // idcode selected after reset
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;  // fixed 01 capture pattern
    localparam logic [3:0]  IR_BYPASS     = 4'hF;
    localparam logic [3:0]  IR_IDCODE     = 4'h1;
    localparam logic [31:0] ID_VALUE      = 32'h00000001;  // arbitrary value, lsb is one
    localparam int          TLR_TMS_EDGES = 5;

endpackage : tap_pkg

//--- design/tck_edge_sampler.sv
// tck_edge_sampler: synchronises the test pins and finds test clock edges
// assumes: test clock far slower than i_clk (125 ns against 10 ns)
`timescale 1ns/100ps
`default_nettype none
module tck_edge_sampler
    import tap_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_tck,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    output logic      o_tck_rise,
    output logic      o_tck_fall,
    output logic      o_tms,
    output logic      o_tdi
);

    logic [1:0] tck_sync_reg;
    logic [1:0] tms_sync_reg;
    logic [1:0] tdi_sync_reg;
    logic       tck_last_reg;

    // ------------------------------------------------------------
    // two-stage synchronisers, first stage read only by second
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tck_sync_reg <= 2'h0;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= 2'h3;
            tck_last_reg <= 1'b0;
        end else begin
            tck_sync_reg <= {tck_sync_reg[0], i_tck};
            tms_sync_reg <= {tms_sync_reg[0], i_tms};
            tdi_sync_reg <= {tdi_sync_reg[0], i_tdi};
            tck_last_reg <= tck_sync_reg[1];
        end
    end

    assign o_tck_rise = tck_sync_reg[1] & ~tck_last_reg;
    assign o_tck_fall = ~tck_sync_reg[1] & tck_last_reg;
    assign o_tms      = tms_sync_reg[1];
    assign o_tdi      = tdi_sync_reg[1];

endmodule : tck_edge_sampler
`default_nettype wire

//--- design/boundary_scan_test_port.sv
// boundary_scan_test_port: tap controller with instruction, idcode and bypass
// assumes: pins already pulled up outside, test reset arrives async low
// Notes on behaviour
// RULE1: all test logic advances on test clock edges
// RULE2: mode select steers every controller transition
// RULE3: data in shifts into selected register
// RULE4: data out changes on falling test clock
// RULE5: data out undriven unless shifting
// RULE6: test reset forces reset state immediately
// RULE7: controller pulses test reset at power-up
// RULE8: floating data, mode, reset read high
// RULE9: unused port: reset tied low, clock low
// RULE10: sample rising edge; five highs reach reset
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port
    import tap_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_tck,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    input  wire logic i_trst_n,
    output logic      o_tdo,
    output logic      o_tdo_oe,
    output logic      o_test_reset
);

    logic                 tck_rise;
    logic                 tck_fall;
    logic                 tms_s;
    logic                 tdi_s;
    tap_state_e           state_reg;
    tap_state_e           state_next;
    logic [IR_WIDTH-1:0]  ir_shift_reg;
    logic [IR_WIDTH-1:0]  ir_reg;
    logic [ID_WIDTH-1:0]  dr_shift_reg;
    logic                 tdo_reg;
    logic                 tdo_oe_reg;
    logic                 trst_meta_reg;
    logic                 trst_n_reg;
    logic                 trst_hit;

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    tck_edge_sampler u_sampler (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_tck      (i_tck),
        .i_tms      (i_tms),      // RULE8
        .i_tdi      (i_tdi),
        .o_tck_rise (tck_rise),   // RULE1
        .o_tck_fall (tck_fall),
        .o_tms      (tms_s),
        .o_tdi      (tdi_s)
    );

    // test reset: async assert, sync release, also clears on system reset
    always_ff @(posedge i_clk or negedge i_trst_n) begin
        if (!i_trst_n) begin
            trst_meta_reg <= 1'b0;
            trst_n_reg    <= 1'b0;
        end else begin
            trst_meta_reg <= 1'b1;
            trst_n_reg    <= trst_meta_reg;
        end
    end

    assign trst_hit = ~trst_n_reg | ~i_rstn;

    // ------------------------------------------------------------
    // state transitions
    // ------------------------------------------------------------
    always_comb begin
        case (state_reg)  // RULE2
            ST_RESET:    state_next = tms_s ? ST_RESET    : ST_IDLE;  // RULE10
            ST_IDLE:     state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_next = tms_s ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_next = tms_s ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
            default:     state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_trst_n) begin
        if (!i_trst_n) begin
            state_reg <= ST_RESET;  // RULE6
        end else if (trst_hit) begin
            state_reg <= ST_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;  // RULE10
        end
    end

    // ------------------------------------------------------------
    // instruction and data registers
    // ------------------------------------------------------------
    wire bypass_sel = (ir_reg != IR_IDCODE);

    always_ff @(posedge i_clk) begin
        if (trst_hit || state_reg == ST_RESET) begin
            ir_reg       <= IR_RESET;
            ir_shift_reg <= IR_CAPTURE;
            dr_shift_reg <= '0;
        end else if (tck_rise) begin
            case (state_reg)
                ST_CAP_IR:   ir_shift_reg <= IR_CAPTURE;
                ST_SHIFT_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};  // RULE3
                ST_UPD_IR:   ir_reg       <= ir_shift_reg;
                ST_CAP_DR:   dr_shift_reg <= bypass_sel ? '0 : ID_VALUE;
                ST_SHIFT_DR: begin
                    if (bypass_sel) begin
                        dr_shift_reg <= {{(ID_WIDTH-1){1'b0}}, tdi_s};  // RULE3
                    end else begin
                        dr_shift_reg <= {tdi_s, dr_shift_reg[ID_WIDTH-1:1]};  // RULE3
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // data out on falling edge
    // ------------------------------------------------------------
    function automatic logic is_shift(input tap_state_e s);
        return (s == ST_SHIFT_DR) || (s == ST_SHIFT_IR);
    endfunction : is_shift

    wire shifting = is_shift(state_reg);
    wire tdo_bit  = (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : dr_shift_reg[0];

    always_ff @(posedge i_clk) begin
        if (trst_hit) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= tdo_bit;   // RULE4
            tdo_oe_reg <= shifting;  // RULE5
        end
    end

    assign o_tdo        = tdo_reg;
    assign o_tdo_oe     = tdo_oe_reg & ~trst_hit;  // RULE5
    assign o_test_reset = (state_reg == ST_RESET);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [2:0] tms_high_reg;
    logic [2:0] tms_high_next;

    // run of tms-high rises, saturating at seven
    assign tms_high_next = !tms_s ? 3'h0 : (tms_high_reg == 3'h7) ? 3'h7 : tms_high_reg + 3'h1;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tms_high_reg <= 3'h0;
        end else if (tck_rise) begin
            tms_high_reg <= tms_high_next;
        end
    end

    a_five_tms_reset: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE10
        tms_high_reg >= 3'(TLR_TMS_EDGES) |-> state_reg == ST_RESET)
        else $error("five tms highs did not reset tap");
    a_state_on_edge: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE1
        !tck_rise |=> $stable(state_reg)) else $error("tap state moved without tck rise");
    a_tdo_on_fall: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE4
        !tck_fall |=> $stable(tdo_reg)) else $error("tdo changed off falling edge");
    a_tdo_hiz_idle: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE5
        tck_fall && !shifting |=> !o_tdo_oe) else $error("tdo driven outside shift");
    a_trst_reset: assert property (@(posedge i_clk) // RULE6
        !i_trst_n |-> state_reg == ST_RESET) else $error("test reset did not force reset state");
    a_tms_steer: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE2
        tck_rise && state_reg == ST_IDLE && tms_s |=> state_reg == ST_SEL_DR) else $error("tms ignored");
    a_ir_shift: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE3
        tck_rise && state_reg == ST_SHIFT_IR |=> ir_shift_reg[IR_WIDTH-1] == $past(tdi_s))
        else $error("tdi not shifted into instruction");
    a_exit_update: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE2
        tck_rise && state_reg == ST_EXIT1_DR && tms_s |=> state_reg == ST_UPD_DR) else $error("bad exit");
    a_ir_capture: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE3
        tck_rise && state_reg == ST_CAP_IR && !trst_hit |=> ir_shift_reg == IR_CAPTURE)
        else $error("instruction capture pattern not loaded");
    a_ir_update: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE3
        tck_rise && state_reg == ST_UPD_IR && !trst_hit |=> ir_reg == $past(ir_shift_reg))
        else $error("instruction not updated");
    a_bypass_shift: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE3
        tck_rise && state_reg == ST_SHIFT_DR && bypass_sel && !trst_hit |=> dr_shift_reg[0] == $past(tdi_s))
        else $error("tdi not shifted into bypass");
    a_id_shift: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE3
        tck_rise && state_reg == ST_SHIFT_DR && !bypass_sel && !trst_hit |=> dr_shift_reg[ID_WIDTH-1] == $past(tdi_s))
        else $error("tdi not shifted into id register");
    a_tdo_value: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE4
        tck_fall && !trst_hit |=> tdo_reg == $past(tdo_bit))
        else $error("tdo not taken from shift register");
    a_tdo_on_shift: assert property (@(posedge i_clk) disable iff (!i_rstn || !i_trst_n) // RULE5
        tck_fall && shifting && !trst_hit |=> o_tdo_oe)
        else $error("tdo not driven in shift");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_ir_update:  cover property (@(posedge i_clk) state_reg == ST_UPD_IR);
    c_dr_shift:   cover property (@(posedge i_clk) state_reg == ST_SHIFT_DR && tck_rise);
    c_tdo_driven: cover property (@(posedge i_clk) o_tdo_oe);
    c_trst_hold:  cover property (@(posedge i_clk) !trst_n_reg && i_rstn);
    c_tms_reset:  cover property (@(posedge i_clk) tms_high_reg >= 3'(TLR_TMS_EDGES));

endmodule : boundary_scan_test_port
`default_nettype wire

//--- verif/tap_ctl_model.sv
// tap_ctl_model: external boundary-scan controller driving the test pins
// assumes: test clock 125 ns, idle low between scans, pull-ups on tms/tdi
`timescale 1ns/100ps
`default_nettype none
module tap_ctl_model (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    initial begin
        o_tck    = 1'b0;
        o_tms    = 1'b1;
        o_tdi    = 1'b1;
        o_trst_n = 1'b1;
    end

    // power-up test reset pulse
    task pulse_reset();
        o_trst_n = 1'b0;
        #40;
        o_trst_n = 1'b1;
        #60;
    endtask : pulse_reset

    task set_trst(input logic v);
        o_trst_n = v;
    endtask : set_trst

    // one test clock period, tdo sampled just before the rise
    task step(input logic tms_v, input logic tdi_v, input logic tdi_on, output logic tdo_v, output logic oe_v);
        o_tms = tms_v;
        o_tdi = tdi_on ? tdi_v : 1'b1;
        #62.5;
        tdo_v = i_tdo_oe ? i_tdo : ~i_tdo;  // released pin has no pull, reads inverted
        oe_v  = i_tdo_oe;
        o_tck = 1'b1;
        #62.5;
        o_tck = 1'b0;
    endtask : step
endmodule : tap_ctl_model
`default_nettype wire

//--- verif/boundary_scan_test_port_test.sv
// boundary_scan_test_port_test: self-checking bench for the test port
// assumes: tap_pkg compiled, controller model drives the test pins
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port_test;
    import tap_pkg::*;
    logic        clk, rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, test_reset, s_tdo, s_oe;
    logic [31:0] id;
    int          mismatches, comparisons;
    // row: tms, tdi, expected oe, expected tdo, expected reset state
    logic [4:0]  rows [21] = '{5'h08, 5'h18, 5'h18, 5'h08, 5'h08, 5'h0E, 5'h0C, 5'h0C, 5'h1C, 5'h18, 5'h08,
                               5'h18, 5'h08, 5'h08, 5'h0C, 5'h06, 5'h1C, 5'h18, 5'h18, 5'h18, 5'h19};

    boundary_scan_test_port u_dut (.i_clk(clk), .i_rstn(rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_test_reset(test_reset));
    tap_ctl_model u_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
        .i_tdo(tdo), .i_tdo_oe(tdo_oe));

    // ------------------------------------------------------------
    // compare and verdict
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task give_verdict();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    task run(input logic tms_v, input logic tdi_v);
        u_ctl.step(tms_v, tdi_v, 1'b0, s_tdo, s_oe);
    endtask : run

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #60000;
        mismatches++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check(test_reset, 1'b1);
        check(tdo_oe, 1'b0);
        rstn = 1'b1;
        u_ctl.pulse_reset();
        foreach (rows[i]) begin
            u_ctl.step(rows[i][4], rows[i][3], 1'b1, s_tdo, s_oe);
            check(s_oe, rows[i][2]);
            if (rows[i][2]) check(s_tdo, rows[i][1]);
            check(test_reset, rows[i][0]);
        end
        // id register selected after reset, tdi left floating
        run(1'b0, 1'b0);
        run(1'b1, 1'b0);
        run(1'b0, 1'b0);
        run(1'b0, 1'b0);
        for (int i = 0; i < 32; i++) begin
            run(i == 31, 1'b0);
            check(s_oe, 1'b1);
            id[i] = s_tdo;
        end
        check(id, ID_VALUE);
        run(1'b1, 1'b0);
        run(1'b0, 1'b0);
        // async test reset in mid shift, test clock held still
        run(1'b1, 1'b0);
        run(1'b0, 1'b0);
        run(1'b0, 1'b0);
        run(1'b0, 1'b0);
        check(s_oe, 1'b1);
        u_ctl.set_trst(1'b0);
        #1;
        check(test_reset, 1'b1);
        check(tdo_oe, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        check(test_reset, 1'b1);
        check(tdo_oe, 1'b0);
        u_ctl.set_trst(1'b1);
        repeat (8) @(posedge clk);
        #1;
        run(1'b0, 1'b0);
        check(test_reset, 1'b0);
        give_verdict();
    end
endmodule : boundary_scan_test_port_test
`default_nettype wire
